// ==== oact_cfg.svh ====
// Constants for the octal converter conversion timing control
`ifndef OACT_CFG_SVH
`define OACT_CFG_SVH

// ----------------------------------------------------------------------
// Pin reset values
// ----------------------------------------------------------------------
// Layout: mode[6:5], clock divide[4], sync_n[3], format[2:0]
`define OACT_PINS_RST     7'h08
`define OACT_MODE_RST     2'h0
`define OACT_DIV_RST      1'h0

// ----------------------------------------------------------------------
// Rate ratios
// ----------------------------------------------------------------------
`define OACT_MODDIV_4     6'h04
`define OACT_MODDIV_8     6'h08
`define OACT_MODDIV_40    6'h28
`define OACT_OSR_64       8'h40
`define OACT_OSR_128      8'h80

// ----------------------------------------------------------------------
// Settling counts, in output conversion periods
// ----------------------------------------------------------------------
`define OACT_SETTLE_SPI   8'h81
`define OACT_SETTLE_FS    8'h80

// ----------------------------------------------------------------------
// Interface format codes and output clip limits
// ----------------------------------------------------------------------
`define OACT_FMT_FS_FIRST 3'h3
`define OACT_FMT_FS_LAST  3'h5
`define OACT_FULL_POS     24'h7FFFFF
`define OACT_FULL_NEG     24'h800000

`endif

// ==== oact_host_model.sv ====
// Host reader model: takes buffered words and may stall on command
module oact_host_model (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            stall,
    input  wire logic            wordValid,
    input  oact_pkg::oact_word_t word,
    output logic                 wordTaken,
    output logic                 sawOne
);
    timeunit 1ns;
    timeprecision 1ps;
    import oact_pkg::*;
    // Ready tracks the stall command only, never the offered word
    assign wordTaken = !stall;
    // ------------------------------------------------------------------
    // Valid-data detection
    // ------------------------------------------------------------------
    // Frames keep being read; the first one bit marks settled data
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sawOne <= 1'b0;
        else if (wordValid && wordTaken && (word.data != 24'h000000))
            sawOne <= 1'b1;
    end
endmodule

// ==== oact_pkg.sv ====
// Types shared by the conversion timing control and its output buffer
package oact_pkg;

    // Operating modes, decoded straight from the two mode pins
    typedef enum logic [1:0] {
        OACT_HIGH_SPEED,
        OACT_HIGH_RES,
        OACT_LOW_POWER,
        OACT_LOW_SPEED
    } oact_mode_t;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_HALT,
        ST_SETTLE,
        ST_LIVE
    } oact_run_t;

    // Configuration pins travelling together through the synchroniser
    typedef struct packed {
        logic [1:0] mode;
        logic       clockDivideSelect;
        logic       sync_n;
        logic [2:0] format;
    } oact_pins_t;

    // One conversion result with its channel number
    typedef struct packed {
        logic [2:0]  channel;
        logic [23:0] data;
    } oact_word_t;

endpackage

// ==== oact_skid_buffer.sv ====
// Two-entry output buffer between filter results and the host reader
module oact_skid_buffer (
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          clkEnable,
    input  wire logic          flush,
    input  wire logic          inValid,
    input  oact_pkg::oact_word_t inWord,
    output logic               inReady,
    output logic               outValid,
    output oact_pkg::oact_word_t outWord,
    input  wire logic          outReady
);
    import oact_pkg::*;

    logic       skidValid;
    oact_word_t skidWord;
    logic       next_skidValid;
    logic       next_outValid;

    // ------------------------------------------------------------------
    // Occupancy
    // ------------------------------------------------------------------
    // Next occupancy; the skid entry only fills while the reader stalls
    always_comb
    begin
        next_skidValid = skidValid;
        next_outValid  = outValid;
        if (flush)
        begin
            next_skidValid = 1'b0;
            next_outValid  = 1'b0;
        end
        else if (outReady || !outValid)
        begin
            next_outValid  = skidValid || (inValid && inReady);
            next_skidValid = 1'b0;
        end
        else if (inValid && inReady)
        begin
            next_skidValid = 1'b1;
        end
    end

    // Flags are registered so ready is never a combinational path back
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            skidValid <= 1'b0;
            outValid  <= 1'b0;
            inReady   <= 1'b1;
        end
        else if (clkEnable)
        begin
            skidValid <= next_skidValid;
            outValid  <= next_outValid;
            inReady   <= !next_skidValid;
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    // Skid entry takes priority so word order is kept
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outWord  <= '0;
            skidWord <= '0;
        end
        else if (clkEnable && !flush)
        begin
            if (outReady || !outValid)
            begin
                outWord <= skidValid ? skidWord : inWord;
            end
            else if (inValid && inReady)
            begin
                skidWord <= inWord;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    skid_full_stall_a: assert property (skidValid |-> !inReady)
        else $error("Buffer accepts input while both entries are full");

    stall_hold_a: assert property (
        (clkEnable && outValid && !outReady && !flush)
        |=> (outValid && $stable(outWord)))
        else $error("Stalled output word changed or vanished");

endmodule

// ==== oact_timing_ctrl.sv ====
// Conversion timing control for an eight-channel delta-sigma converter
`include "oact_cfg.svh"

module oact_timing_ctrl (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               clkEnable,
    input  wire logic [1:0]         modeSelect,
    input  wire logic               clockDivideSelect,
    input  wire logic               sync_n,
    input  wire logic [2:0]         formatSelect,
    input  wire logic               filterValid,
    input  wire logic [2:0]         filterChannel,
    input  wire logic signed [25:0] filterSum,
    input  wire logic               wordTaken,
    output logic                    filterReady,
    output logic                    filterClear,
    output logic                    conversionRun,
    output logic                    modulatorStrobe,
    output logic                    conversionStrobe,
    output logic                    sampleValid_n,
    output logic                    frameFormat,
    output logic                    wordValid,
    output oact_pkg::oact_word_t    word
);
    import oact_pkg::*;

    // ------------------------------------------------------------------
    // Ratio and clipping functions
    // ------------------------------------------------------------------
    // Master clocks per modulator sample
    function automatic logic [5:0] modDivOf(input logic [1:0] mode,
                                            input logic       div);
        case (oact_mode_t'(mode))
            OACT_LOW_POWER: modDivOf = div ? `OACT_MODDIV_8
                                           : `OACT_MODDIV_4;
            OACT_LOW_SPEED: modDivOf = div ? `OACT_MODDIV_40
                                           : `OACT_MODDIV_8;
            default:        modDivOf = `OACT_MODDIV_4;
        endcase
    endfunction

    // Modulator samples per output word
    function automatic logic [7:0] osrOf(input logic [1:0] mode);
        osrOf = (oact_mode_t'(mode) == OACT_HIGH_RES) ? `OACT_OSR_128
                                                      : `OACT_OSR_64;
    endfunction

    // Master clocks per output word; largest is 2560, fits 12 bits
    function automatic logic [11:0] periodOf(input logic [1:0] mode,
                                             input logic       div);
        logic [13:0] product;
        product  = modDivOf(mode, div) * osrOf(mode);
        periodOf = product[11:0];
    endfunction

    // Saturate the wide filter sum to 24-bit two's complement
    function automatic logic [23:0] clip24(input logic signed [25:0] v);
        if (v > $signed({2'h0, `OACT_FULL_POS}))
            clip24 = `OACT_FULL_POS;
        else if (v < $signed({2'h3, `OACT_FULL_NEG}))
            clip24 = `OACT_FULL_NEG;
        else
            clip24 = v[23:0];
    endfunction

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    oact_pins_t pinRaw;
    oact_pins_t pinMeta;
    oact_pins_t pinMid;
    oact_pins_t pinLate;
    oact_pins_t pinStable;

    assign pinRaw = '{mode: modeSelect,
                      clockDivideSelect: clockDivideSelect,
                      sync_n: sync_n,
                      format: formatSelect};

    // Three stages; a change is taken only once stages two and three agree
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinMeta   <= `OACT_PINS_RST;
            pinMid    <= `OACT_PINS_RST;
            pinLate   <= `OACT_PINS_RST;
            pinStable <= `OACT_PINS_RST;
        end
        else if (clkEnable)
        begin
            pinMeta <= pinRaw;
            pinMid  <= pinMeta;
            pinLate <= pinMid;
            if (pinMid == pinLate)
                pinStable <= pinLate;
        end
    end

    // ------------------------------------------------------------------
    // Restart decisions
    // ------------------------------------------------------------------
    oact_run_t  state;
    logic [1:0] activeMode;
    logic       activeDiv;
    logic       modeChange;
    logic       halting;
    logic       restart;
    logic       clearNow;
    logic       isFrame;

    // Mode pins compared every cycle, so any change restarts settling
    assign modeChange = (pinStable.mode != activeMode) ||
                        (pinStable.clockDivideSelect != activeDiv);
    assign halting    = !pinStable.sync_n;
    assign restart    = pinStable.sync_n &&
                        ((state == ST_HALT) || modeChange);
    // One clear serves all eight channels so they never drift apart
    assign clearNow   = halting || restart;
    assign isFrame    = (pinStable.format >= `OACT_FMT_FS_FIRST) &&
                        (pinStable.format <= `OACT_FMT_FS_LAST);

    // Active configuration follows the pins whenever the filter clears
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            activeMode <= `OACT_MODE_RST;
            activeDiv  <= `OACT_DIV_RST;
        end
        else if (clkEnable && clearNow)
        begin
            activeMode <= pinStable.mode;
            activeDiv  <= pinStable.clockDivideSelect;
        end
    end

    // ------------------------------------------------------------------
    // Rate counters
    // ------------------------------------------------------------------
    logic [11:0] period;
    logic [5:0]  modDiv;
    logic [11:0] periodCount;
    logic [5:0]  modCount;
    logic        periodEnd;
    logic        modEnd;
    logic        running;

    assign period    = periodOf(activeMode, activeDiv);
    assign modDiv    = modDivOf(activeMode, activeDiv);
    assign running   = (state != ST_HALT) && !clearNow;
    assign periodEnd = running && (periodCount == period - 12'h001);
    assign modEnd    = running && (modCount == modDiv - 6'h01);

    // Both counters restart together so word and modulator edges align
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            periodCount <= 12'h000;
            modCount    <= 6'h00;
        end
        else if (clkEnable)
        begin
            if (!running)
            begin
                periodCount <= 12'h000;
                modCount    <= 6'h00;
            end
            else
            begin
                periodCount <= periodEnd ? 12'h000
                                         : periodCount + 12'h001;
                modCount    <= modEnd ? 6'h00 : modCount + 6'h01;
            end
        end
    end

    // Strobes are registered so the outputs come straight from flops
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conversionStrobe <= 1'b0;
            modulatorStrobe  <= 1'b0;
        end
        else if (clkEnable)
        begin
            conversionStrobe <= periodEnd;
            modulatorStrobe  <= modEnd;
        end
    end

    // ------------------------------------------------------------------
    // Settling sequencer
    // ------------------------------------------------------------------
    logic [7:0] settleCount;
    logic [7:0] settleTarget;
    logic       settleDone;

    assign settleTarget = isFrame ? `OACT_SETTLE_FS
                                  : `OACT_SETTLE_SPI;
    assign settleDone   = (settleCount >= settleTarget);

    // Counts whole output periods since the last clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            settleCount <= 8'h00;
        else if (clkEnable)
        begin
            if (clearNow)
                settleCount <= 8'h00;
            else if (periodEnd && !settleDone)
                settleCount <= settleCount + 8'h01;
        end
    end

    // Halt while sync is low, settle after any restart, then go live
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= ST_SETTLE;
        else if (clkEnable)
        begin
            case (state)
                ST_HALT:
                    if (!halting)
                        state <= ST_SETTLE;
                ST_SETTLE:
                    if (halting)
                        state <= ST_HALT;
                    else if (!restart && settleDone)
                        state <= ST_LIVE;
                ST_LIVE:
                    if (halting)
                        state <= ST_HALT;
                    else if (restart)
                        state <= ST_SETTLE;
                default:
                    state <= ST_HALT;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output path and status flags
    // ------------------------------------------------------------------
    logic       live;
    logic       bufInValid;
    oact_word_t bufInWord;

    // Frame format passes zeros while settling so the host sees no ones;
    // SPI simply drops unsettled words since data-ready stays high
    assign live       = (state == ST_LIVE) && !clearNow;
    assign bufInValid = filterValid && running && (live || isFrame);
    assign bufInWord  = '{channel: filterChannel,
                          data: live ? clip24(filterSum)
                                     : 24'h000000};

    // Flushing on a clear drops wordValid at the next edge; word keeps its last value
    oact_skid_buffer u_buffer (
        .clk      (clk),
        .reset_n  (reset_n),
        .clkEnable(clkEnable),
        .flush    (clearNow),
        .inValid  (bufInValid),
        .inWord   (bufInWord),
        .inReady  (filterReady),
        .outValid (wordValid),
        .outWord  (word),
        .outReady (wordTaken)
    );

    // Data-ready is low only for settled SPI words waiting to be read
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sampleValid_n <= 1'b1;
            filterClear   <= 1'b1;
            conversionRun <= 1'b0;
            frameFormat   <= 1'b0;
        end
        else if (clkEnable)
        begin
            sampleValid_n <= clearNow || isFrame || (state != ST_LIVE) ||
                             !wordValid;
            filterClear   <= clearNow;
            conversionRun <= !halting;
            frameFormat   <= isFrame;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [11:0] gapCount;
    logic        gapSeen;

    // Clocks between word strobes, restarted by every strobe; every clear drops gapSeen
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gapCount <= 12'h000;
            gapSeen  <= 1'b0;
        end
        else if (clkEnable)
        begin
            gapCount <= conversionStrobe ? 12'h001 : gapCount + 12'h001;
            gapSeen  <= clearNow ? 1'b0 : (gapSeen || conversionStrobe);
        end
    end

    word_period_a: assert property (
        (conversionStrobe && gapSeen) |-> (gapCount == period))
        else $error("Word period differs from selected ratio");

    mod_align_a: assert property (
        conversionStrobe |-> modulatorStrobe)
        else $error("Word strobe not on a modulator sample");

    sync_clear_a: assert property (
        (clkEnable && halting) |=> (filterClear && !conversionRun))
        else $error("Sync low did not halt and clear");

    sync_restart_a: assert property (
        (clkEnable && state == ST_HALT && !halting)
        |=> (state == ST_SETTLE && settleCount == 8'h00))
        else $error("Sync release did not restart settling");

    ready_sync_a: assert property (
        (clkEnable && clearNow) |=> sampleValid_n)
        else $error("Data-ready low during a clear");

    ready_settle_a: assert property (
        $fell(sampleValid_n) |-> (settleCount == `OACT_SETTLE_SPI && !isFrame))
        else $error("Data-ready fell before settling");

    // Watches the buffered output, so a stale settled word would be caught
    frame_zero_a: assert property (
        (frameFormat && wordValid && state != ST_LIVE)
        |-> (word.data == 24'h000000))
        else $error("Unsettled frame word not zero");

    clip_limit_a: assert property (
        (live && filterSum > 26'sh07FFFFF)
        |-> (bufInWord.data == `OACT_FULL_POS))
        else $error("Positive overrange not clipped");

    mode_change_a: assert property (
        (clkEnable && state != ST_HALT && !halting && modeChange)
        |=> (filterClear && activeMode == $past(pinStable.mode)))
        else $error("Mode change did not restart");

    spi_live_c: cover property (!sampleValid_n ##1 wordTaken);
    frame_live_c: cover property (
        frameFormat && state == ST_LIVE && wordValid);
    sync_pulse_c: cover property (
        halting ##1 !halting ##[1:300] conversionStrobe);
    buffer_full_c: cover property (!filterReady && wordValid);

endmodule

// ==== octal_adc_conversion_timing_control_tb.sv ====
// Self-checking bench for the conversion timing control
module octal_adc_conversion_timing_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import oact_pkg::*;
    logic              clk, reset_n, clockDivideSelect, sync_n, stall;
    logic              clkEnable;
    logic [1:0]        modeSelect;
    logic [2:0]        formatSelect, filterChannel;
    logic              filterValid, wordTaken, filterReady, filterClear;
    logic              conversionRun, modulatorStrobe, conversionStrobe;
    logic              sampleValid_n, frameFormat, wordValid, sawOne;
    logic signed [25:0] filterSum;
    oact_word_t        word;
    int                error_cnt, total_checks, cycles;

    oact_timing_ctrl uut (.clk(clk), .reset_n(reset_n), .clkEnable(clkEnable),
        .modeSelect(modeSelect), .clockDivideSelect(clockDivideSelect),
        .sync_n(sync_n), .formatSelect(formatSelect),
        .filterValid(filterValid), .filterChannel(filterChannel),
        .filterSum(filterSum), .wordTaken(wordTaken),
        .filterReady(filterReady), .filterClear(filterClear),
        .conversionRun(conversionRun), .modulatorStrobe(modulatorStrobe),
        .conversionStrobe(conversionStrobe), .sampleValid_n(sampleValid_n),
        .frameFormat(frameFormat), .wordValid(wordValid), .word(word));
    oact_host_model host (.clk(clk), .reset_n(reset_n), .stall(stall),
        .wordValid(wordValid), .word(word), .wordTaken(wordTaken),
        .sawOne(sawOne));

    // ------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------
    // 25 MHz stays under every mode's clock ceiling
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // A hang costs one mismatch and ends the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Change mode pins, then time one output period in clocks and count its modulator strobes
    task automatic t_rate(input logic [1:0] m, input logic d,
                          input int per, input int md);
        int n, k;
        modeSelect = m;
        clockDivideSelect = d;
        repeat (5) @(negedge clk);
        check("restart", 1, filterClear);
        n = 0;
        k = 0;
        while (conversionStrobe !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            k += (modulatorStrobe === 1'b1);
        end while (conversionStrobe !== 1'b1 && n < 3000);
        check("period", per, n);
        check("modrate", per / md, k);
    endtask
    // Pulse sync, then count periods until settled data appear
    task automatic t_settle(input logic [2:0] f, input int lim);
        int n, early, t;
        formatSelect = f;
        filterValid = 1'b1;
        sync_n = 1'b0;
        repeat (5) @(negedge clk);
        check("clear", 1, filterClear);
        check("run", 0, conversionRun);
        check("dataready", 1, sampleValid_n);
        check("fmt", f != 3'h0, frameFormat);
        sync_n = 1'b1;
        // The restart itself holds the clear one more cycle
        repeat (6) @(negedge clk);
        check("rerun", 1, {conversionRun, filterClear} == 2'b10);
        n = 0;
        early = 0;
        t = 0;
        while (!(wordValid === 1'b1 && word.data === 24'h000123) && t < 40000)
        begin
            early += (wordValid === 1'b1 || sampleValid_n === 1'b0);
            n += (conversionStrobe === 1'b1);
            t++;
            @(negedge clk);
        end
        check("settle", 1, n >= lim - 1 && n <= lim);
        check("early", f != 3'h0, early > 0);
    endtask
    // Fill the buffer with clipped values while the host stalls, then drain
    task automatic t_clip();
        filterValid = 1'b0;
        repeat (4) @(negedge clk);
        stall = 1'b1;
        filterValid = 1'b1;
        filterSum = 26'sh1FFFFFF;
        @(negedge clk);
        filterSum = -26'sh2000000;
        @(negedge clk);
        filterSum = 26'sh0000123;
        repeat (2) @(negedge clk);
        check("full", 0, filterReady);
        check("pos", 32'h057FFFFF, {word.channel, word.data});
        check("ready", 0, sampleValid_n);
        filterValid = 1'b0;
        stall = 1'b0;
        // Enable low must freeze the buffer even though the host is ready
        clkEnable = 1'b0;
        @(negedge clk);
        check("freeze", 24'h7FFFFF, word.data);
        clkEnable = 1'b1;
        @(negedge clk);
        check("neg", 24'h800000, word.data);
        repeat (2) @(negedge clk);
        check("empty", 0, wordValid);
    endtask

    initial
    begin
        {reset_n, modeSelect, clockDivideSelect, stall} = 5'h00;
        {formatSelect, filterValid, filterSum} = '0;
        sync_n = 1'b1;
        clkEnable = 1'b1;
        filterChannel = 3'h5;
        repeat (3) @(negedge clk);
        check("rstclr", 3'h7, {filterClear, sampleValid_n, filterReady});
        reset_n = 1'b1;
        t_rate(2'h0, 1'b1, 256, 4);
        t_rate(2'h1, 1'b0, 512, 4);
        t_rate(2'h2, 1'b1, 512, 8);
        t_rate(2'h2, 1'b0, 256, 4);
        t_rate(2'h3, 1'b1, 2560, 40);
        t_rate(2'h3, 1'b0, 512, 8);
        t_rate(2'h1, 1'b1, 512, 4);
        t_rate(2'h0, 1'b0, 256, 4);
        filterSum = 26'sh0000123;
        t_settle(3'h4, 128);
        // The host flag is set on the edge after the word appears
        @(negedge clk);
        check("sawone", 1, sawOne);
        // Second pulse realigns after the format change
        t_settle(3'h0, 129);
        t_clip();
        finish_test();
    end
endmodule
